// [common/sfp_pkg.sv]
// Shared types and constants for the serial flash pin front end
package sfp_pkg;

  // ****************************************
  // Instruction codes and widths
  // ****************************************
  localparam logic [7:0] CMD_ENTER_FOUR_LANE = 8'h35;
  localparam logic [7:0] CMD_EXIT_FOUR_LANE  = 8'hF5;
  localparam int         CMD_BITS            = 8;
  localparam logic [2:0] BIT_CNT_RESET       = 3'h0;
  localparam logic [7:0] BYTE_RESET          = 8'h00;

  // ****************************************
  // Status protection field positions
  // ****************************************
  localparam int STAT_GUARD0_POS = 2;
  localparam int STAT_GUARD3_POS = 5;
  localparam int STAT_QE_POS     = 6;
  localparam int STAT_LOCK_POS   = 7;
  localparam logic [7:0] STAT_RESET      = 8'h00;
  localparam logic [7:0] STAT_GUARD_MASK = 8'hFC;

  // ****************************************
  // Lane width
  // ****************************************
  typedef enum logic [1:0] {
    SFP_LANE_ONE  = 2'b00,
    SFP_LANE_TWO  = 2'b01,
    SFP_LANE_FOUR = 2'b10
  } sfp_lane_e;

  typedef struct packed {
    logic [3:0] out_val;
    logic [3:0] out_en;
  } sfp_pad_s;

endpackage : sfp_pkg

// [design/sfp_pin_front.sv]
// Pin-level front end of a serial flash: select, clock edges, lanes, protection
// Operation
// RULE_01 - Select high: deselected, all outputs floated, standby asserted.
// RULE_02 - Select low: leave standby, become active for instructions and data.
// RULE_03 - After power-up, no instruction accepted before a select falling edge.
// RULE_04 - Data inputs ignored while select is high.
// RULE_05 - Single lane: inbound bits sampled on serial clock rising edge.
// RULE_06 - Single lane: outbound bits change on serial clock falling edge.
// RULE_07 - Dual and quad: lanes zero and one bidirectional, same edge usage.
// RULE_08 - Quad width uses protect pin as lane two, pause pin as lane three.
// RULE_09 - Lock set and protect low: lock, quad and guard bits not writable.
// RULE_10 - Lock clear: status bits writable whatever the protect pin level.
// RULE_11 - Quad enable set: protect function off, pin is lane two only.
// RULE_12 - Selected with pause low: float output, freeze sequence; high resumes. Code ignores pause while quad enable or four-lane command mode is set.
// RULE_13 - Clock idle low or idle high both work; rising in, falling out.
// RULE_14 - 35h enters four-lane command mode, F5h leaves; reset returns single.
// RULE_15 - Select rising edge discards any partly received instruction.
`timescale 1ns/100ps
module sfp_pin_front (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             chip_sel_n,
  input  wire logic             serial_clk,
  input  wire logic [3:0]       data_line_in,
  output sfp_pkg::sfp_pad_s     pad_out,
  output logic                  standby,
  input  wire logic             soft_reset,
  input  wire sfp_pkg::sfp_lane_e xfer_lanes,
  input  wire logic             out_phase,
  input  wire logic [7:0]       tx_byte,
  output logic                  tx_take,
  output logic [7:0]            rx_byte,
  output logic                  rx_valid,
  output logic                  rx_first,
  output logic                  four_lane_command_mode,
  input  wire logic             status_wr,
  input  wire logic [7:0]       status_wdata,
  output logic [7:0]            status_reg
);

  // ****************************************
  // Pin synchronisation and edge detection
  // ****************************************
  logic [5:0] pins_sync;
  logic       cs_n_s;
  logic       sck_s;
  logic [3:0] din_s;
  logic       sck_d_reg;
  logic       cs_d_reg;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_rise;
  logic       cs_fall;
  logic [2:0] warm_reg;

  sfp_sync #(
    .WIDTH (6),
    .INIT  (32'h0000_0001)
  ) u_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .async_in ({data_line_in, serial_clk, chip_sel_n}),
    .sync_out (pins_sync)
  );

  assign cs_n_s = pins_sync[0];
  assign sck_s  = pins_sync[1];
  assign din_s  = pins_sync[5:2];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_d_reg <= 1'b0;
      cs_d_reg  <= 1'b1;
      warm_reg  <= 3'h0;
    end else begin
      sck_d_reg <= sck_s;
      cs_d_reg  <= cs_n_s;
      warm_reg  <= {warm_reg[1:0], 1'b1};
    end
  end

  // Edges only, so the parked clock level never matters
  assign sck_rise = sck_s & ~sck_d_reg;  // [RULE_13]
  assign sck_fall = ~sck_s & sck_d_reg;  // [RULE_13]
  assign cs_rise  = cs_n_s & ~cs_d_reg;
  assign cs_fall  = ~cs_n_s & cs_d_reg;

  // ****************************************
  // Select, arming and pause
  // ****************************************
  logic armed_reg;
  logic pause_n;
  logic active;
  logic run;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      armed_reg <= 1'b0;
    end else if (cs_rise) begin
      armed_reg <= 1'b0;
    end else if (cs_fall && warm_reg[2]) begin
      // Select held low through reset shows a false fall until the synchroniser holds real pin levels
      armed_reg <= 1'b1;  // [RULE_03]
    end
  end

  assign standby = cs_n_s;                                  // [RULE_01] [RULE_02]
  assign active  = armed_reg & ~cs_n_s;                     // [RULE_04]
  assign pause_n = status_reg[sfp_pkg::STAT_QE_POS] | four_lane_command_mode | din_s[3];  // [RULE_12]
  assign run     = active & pause_n;

  // ****************************************
  // Lane width
  // ****************************************
  logic [1:0] lanes;
  logic [2:0] step;

  always_comb begin
    lanes = xfer_lanes;
    if (four_lane_command_mode) begin
      lanes = sfp_pkg::SFP_LANE_FOUR;
    end
    case (lanes)
      sfp_pkg::SFP_LANE_TWO:  step = 3'h2;
      sfp_pkg::SFP_LANE_FOUR: step = 3'h4;
      default:                step = 3'h1;
    endcase
  end

  // ****************************************
  // Inbound shifter, rising edges
  // ****************************************
  logic [7:0] sh_reg;
  logic [2:0] rcnt_reg;
  logic       first_reg;
  logic [7:0] sh_next;
  logic [2:0] rcnt_next;

  always_comb begin
    case (lanes)
      sfp_pkg::SFP_LANE_TWO:  sh_next = {sh_reg[5:0], din_s[1:0]};  // [RULE_07]
      sfp_pkg::SFP_LANE_FOUR: sh_next = {sh_reg[3:0], din_s};       // [RULE_08]
      default:                sh_next = {sh_reg[6:0], din_s[0]};    // [RULE_05]
    endcase
    rcnt_next = rcnt_reg + step;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sh_reg    <= sfp_pkg::BYTE_RESET;
      rcnt_reg  <= sfp_pkg::BIT_CNT_RESET;
      first_reg <= 1'b1;
      rx_byte   <= sfp_pkg::BYTE_RESET;
      rx_valid  <= 1'b0;
      rx_first  <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (cs_n_s) begin
        rcnt_reg  <= sfp_pkg::BIT_CNT_RESET;  // [RULE_15]
        first_reg <= 1'b1;
      end else if (run && !out_phase && sck_rise) begin
        sh_reg   <= sh_next;
        rcnt_reg <= rcnt_next;
        if (rcnt_next == sfp_pkg::BIT_CNT_RESET) begin
          rx_byte   <= sh_next;
          rx_valid  <= 1'b1;
          rx_first  <= first_reg;
          first_reg <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Four-lane command mode
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      four_lane_command_mode <= 1'b0;
    end else if (soft_reset) begin
      four_lane_command_mode <= 1'b0;  // [RULE_14]
    end else if (rx_valid && rx_first) begin
      if (rx_byte == sfp_pkg::CMD_ENTER_FOUR_LANE) begin
        four_lane_command_mode <= 1'b1;  // [RULE_14]
      end else if (rx_byte == sfp_pkg::CMD_EXIT_FOUR_LANE) begin
        four_lane_command_mode <= 1'b0;  // [RULE_14]
      end
    end
  end

  // ****************************************
  // Status protection
  // ****************************************
  logic hw_locked;

  assign hw_locked = status_reg[sfp_pkg::STAT_LOCK_POS] & ~din_s[2]
                     & ~status_reg[sfp_pkg::STAT_QE_POS];  // [RULE_09] [RULE_10] [RULE_11]

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= sfp_pkg::STAT_RESET;
    end else if (status_wr) begin
      if (hw_locked) begin
        status_reg <= (status_reg & sfp_pkg::STAT_GUARD_MASK)
                      | (status_wdata & ~sfp_pkg::STAT_GUARD_MASK);  // [RULE_09]
      end else begin
        status_reg <= status_wdata;  // [RULE_10]
      end
    end
  end

  // ****************************************
  // Outbound shifter, falling edges
  // ****************************************
  logic [7:0] tx_reg;
  logic [2:0] tcnt_reg;
  logic [3:0] oval_reg;
  logic       tx_load;

  assign tx_load = (tcnt_reg == sfp_pkg::BIT_CNT_RESET);
  assign tx_take = run & out_phase & sck_fall & tx_load;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_reg   <= sfp_pkg::BYTE_RESET;
      tcnt_reg <= sfp_pkg::BIT_CNT_RESET;
      oval_reg <= 4'h0;
    end else if (cs_n_s) begin
      tcnt_reg <= sfp_pkg::BIT_CNT_RESET;
    end else if (run && out_phase && sck_fall) begin  // [RULE_06] [RULE_07]
      tcnt_reg <= tcnt_reg + step;
      case (lanes)
        sfp_pkg::SFP_LANE_TWO: begin
          oval_reg <= tx_load ? {2'h0, tx_byte[7:6]} : {2'h0, tx_reg[7:6]};
          tx_reg   <= tx_load ? {tx_byte[5:0], 2'h0} : {tx_reg[5:0], 2'h0};
        end
        sfp_pkg::SFP_LANE_FOUR: begin
          oval_reg <= tx_load ? tx_byte[7:4] : tx_reg[7:4];
          tx_reg   <= tx_load ? {tx_byte[3:0], 4'h0} : {tx_reg[3:0], 4'h0};
        end
        default: begin
          oval_reg <= tx_load ? {2'h0, tx_byte[7], 1'b0} : {2'h0, tx_reg[7], 1'b0};
          tx_reg   <= tx_load ? {tx_byte[6:0], 1'b0} : {tx_reg[6:0], 1'b0};
        end
      endcase
    end
  end

  // ****************************************
  // Pad enables
  // ****************************************
  always_comb begin
    pad_out.out_val = oval_reg;
    pad_out.out_en  = 4'h0;  // [RULE_01] [RULE_12]
    if (run && out_phase) begin
      case (lanes)
        sfp_pkg::SFP_LANE_TWO:  pad_out.out_en = 4'h3;
        sfp_pkg::SFP_LANE_FOUR: pad_out.out_en = 4'hF;  // [RULE_08]
        default:                pad_out.out_en = 4'h2;  // [RULE_06]
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_deselect_float: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cs_n_s |-> pad_out.out_en == 4'h0) else $error("pads driven while deselected");  // [RULE_01]
  a_standby_follows: assert property (@(posedge ref_clk) disable iff (!reset_n)
    standby == cs_n_s) else $error("standby mismatch");  // [RULE_02]
  a_no_rx_unarmed: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !armed_reg |=> !rx_valid) else $error("byte taken before select fall");  // [RULE_03]
  a_no_rx_deselect: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $past(cs_n_s) |-> !rx_valid) else $error("byte taken while deselected");  // [RULE_04]
  a_pause_float: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !pause_n |-> pad_out.out_en == 4'h0) else $error("pads driven in pause");  // [RULE_12]
  a_lock_holds: assert property (@(posedge ref_clk) disable iff (!reset_n)
    status_wr && hw_locked |=> status_reg[7:2] == $past(status_reg[7:2]))
    else $error("locked status bits changed");  // [RULE_09]
  a_unlock_writes: assert property (@(posedge ref_clk) disable iff (!reset_n)
    status_wr && !status_reg[sfp_pkg::STAT_LOCK_POS] |=> status_reg == $past(status_wdata))
    else $error("unlocked write lost");  // [RULE_10]
  a_enter_four: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rx_valid && rx_first && !soft_reset && rx_byte == sfp_pkg::CMD_ENTER_FOUR_LANE
    |=> four_lane_command_mode) else $error("four-lane entry missed");  // [RULE_14]
  a_fresh_after_cs: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cs_rise |=> rcnt_reg == sfp_pkg::BIT_CNT_RESET && first_reg)
    else $error("partial instruction kept");  // [RULE_15]

endmodule // sfp_pin_front

// [design/sfp_sync.sv]
// Two-flop synchroniser for a bus of pin inputs
`timescale 1ns/100ps
module sfp_sync #(
  parameter int          WIDTH = 1,
  parameter logic [31:0] INIT  = 32'h0000_0000
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= INIT[WIDTH-1:0];
      sync_out <= INIT[WIDTH-1:0];
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // sfp_sync

// [dv/sfp_host_model.sv]
// Behavioural host that drives select, serial clock and data lanes
`timescale 1ns/100ps
module sfp_host_model (
  output logic            chip_sel_n,
  output logic            serial_clk,
  output logic [3:0]      host_line,
  input  wire logic [3:0] line_in
);
  logic idle_high;

  // ****************************************
  // Bus actions
  // ****************************************
  initial begin
    chip_sel_n = 1'b1;
    serial_clk = 1'b0;
    idle_high  = 1'b0;
    host_line  = 4'hC;
  end

  // Parks the clock at its idle level, then moves select
  task automatic sel(input logic lvl);
    #83;
    serial_clk = idle_high;
    chip_sel_n = lvl;
    #83;
  endtask

  // Lanes change while clock is low; read data taken on rises
  task automatic shift(input logic [7:0] tx, input int lanes, input int beats, input logic rd,
                       output logic [7:0] rx);
    logic [1:0] keep;
    keep = host_line[3:2];
    rx   = 8'h00;
    for (int i = 0; i < beats; i++) begin
      serial_clk = 1'b0;
      if (rd) begin
        host_line[1:0] = ~host_line[1:0];
      end else begin
        for (int j = 0; j < lanes; j++) begin
          host_line[j] = tx[7 - i * lanes - (lanes - 1 - j)];
        end
      end
      #80;
      serial_clk = 1'b1;
      rx = {rx[6:0], line_in[1]};
      #80;
    end
    serial_clk     = idle_high;
    host_line[3:2] = keep;
    host_line[1:0] = ~host_line[1:0];
  endtask
endmodule // sfp_host_model

// [dv/sfp_pin_front_test.sv]
// Self-checking bench for the serial flash pin front end
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module sfp_pin_front_test;
  logic               ref_clk, reset_n, soft_reset, out_phase, status_wr, seen_first, tx_take;
  logic               standby, rx_valid, rx_first, four_lane_command_mode, chip_sel_n, serial_clk;
  logic [7:0]         tx_byte, status_wdata, rx_byte, status_reg, got, rx_last;
  logic [3:0]         host_line, line_in;
  sfp_pkg::sfp_lane_e xfer_lanes;
  sfp_pkg::sfp_pad_s  pad_out;
  int                 err_count, checks, rx_cnt, take_cnt, n_pre;

  // ****************************************
  // Structure
  // ****************************************
  assign line_in = (pad_out.out_en & pad_out.out_val) | (~pad_out.out_en & host_line);
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (tx_take === 1'b1) begin
      take_cnt++;
    end
    if (rx_valid === 1'b1) begin
      rx_cnt++;
      rx_last    <= rx_byte;
      seen_first <= rx_first;
    end
  end

  sfp_host_model u_host (.chip_sel_n(chip_sel_n), .serial_clk(serial_clk), .host_line(host_line),
                         .line_in(line_in));
  sfp_pin_front u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
    .data_line_in(line_in), .pad_out(pad_out), .standby(standby), .soft_reset(soft_reset),
    .xfer_lanes(xfer_lanes), .out_phase(out_phase), .tx_byte(tx_byte), .tx_take(tx_take), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_first(rx_first), .four_lane_command_mode(four_lane_command_mode),
    .status_wr(status_wr), .status_wdata(status_wdata), .status_reg(status_reg));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic send(input logic [7:0] d, input int lanes, input logic [7:0] exp_b, input int exp_n);
    int n0;
    n0 = rx_cnt;
    u_host.shift(d, lanes, 8 / lanes, 1'b0, got);
    `CHK(rx_cnt - n0, exp_n)
    if (exp_n > 0) `CHK(rx_last, exp_b)
  endtask

  // Waits until the protect pin level has crossed the synchroniser
  task automatic wr_status(input logic [7:0] d, input logic [7:0] exp_s);
    repeat (3) @(posedge ref_clk);
    #1;
    status_wr    = 1'b1;
    status_wdata = d;
    @(posedge ref_clk);
    #1;
    status_wr = 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK(status_reg, exp_s)
  endtask

  task automatic end_of_test;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    #500_000;
    err_count++;
    end_of_test;
  end

  initial begin
    ref_clk = 1'b0; reset_n = 1'b0; soft_reset = 1'b0; out_phase = 1'b0; status_wr = 1'b0;
    status_wdata = 8'h00; tx_byte = 8'h96; xfer_lanes = sfp_pkg::SFP_LANE_ONE;
    err_count = 0; checks = 0; rx_cnt = 0; take_cnt = 0; n_pre = 0;
    #2;
    u_host.chip_sel_n = 1'b0;
    repeat (12) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    `CHK(pad_out.out_en, 4'h0)
    `CHK(status_reg, 8'h00)
    `CHK(four_lane_command_mode, 1'b0)
    send(8'hA5, 1, 8'h00, 0);
    u_host.sel(1'b1);
    `CHK(standby, 1'b1)
    send(8'h3C, 1, 8'h00, 0);
    u_host.sel(1'b0);
    `CHK(standby, 1'b0)
    send(8'hA5, 1, 8'hA5, 1);
    `CHK(seen_first, 1'b1)
    send(8'h5A, 1, 8'h5A, 1);
    `CHK(seen_first, 1'b0)
    u_host.shift(8'hFF, 1, 4, 1'b0, got);
    u_host.sel(1'b1);
    u_host.sel(1'b0);
    send(8'h81, 1, 8'h81, 1);
    `CHK(seen_first, 1'b1)
    xfer_lanes = sfp_pkg::SFP_LANE_TWO;
    send(8'hC3, 2, 8'hC3, 1);
    u_host.host_line[2] = 1'b0;
    wr_status(8'hBF, 8'hBF);
    wr_status(8'h00, 8'hBC);
    u_host.host_line[2] = 1'b1;
    wr_status(8'hC0, 8'hC0);
    u_host.host_line[2] = 1'b0;
    wr_status(8'h7C, 8'h7C);
    xfer_lanes = sfp_pkg::SFP_LANE_FOUR;
    send(8'h69, 4, 8'h69, 1);
    xfer_lanes = sfp_pkg::SFP_LANE_ONE;
    u_host.sel(1'b1);
    u_host.sel(1'b0);
    send(8'h35, 1, 8'h35, 1);
    u_host.sel(1'b1);
    `CHK(four_lane_command_mode, 1'b1)
    u_host.sel(1'b0);
    send(8'hF5, 4, 8'hF5, 1);
    u_host.sel(1'b1);
    `CHK(four_lane_command_mode, 1'b0)
    u_host.sel(1'b0);
    send(8'h35, 1, 8'h35, 1);
    u_host.sel(1'b1);
    @(posedge ref_clk);
    #1;
    soft_reset = 1'b1;
    @(posedge ref_clk);
    #1;
    soft_reset = 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK(four_lane_command_mode, 1'b0)
    wr_status(8'h00, 8'h00);
    u_host.idle_high = 1'b1;
    u_host.sel(1'b0);
    send(8'h24, 1, 8'h24, 1);
    @(posedge ref_clk);
    #1;
    out_phase = 1'b1;
    u_host.shift(8'h00, 1, 8, 1'b1, got);
    `CHK(got, 8'h96)
    `CHK(take_cnt, 1)
    @(posedge ref_clk);
    #1;
    tx_byte = 8'h5C;
    u_host.shift(8'h00, 1, 8, 1'b1, got);
    `CHK(got, 8'h5C)
    `CHK(take_cnt, 2)
    u_host.host_line[3] = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    `CHK(pad_out.out_en, 4'h0)
    u_host.host_line[3] = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    `CHK(pad_out.out_en[1], 1'b1)
    u_host.sel(1'b1);
    `CHK(pad_out.out_en, 4'h0)
    @(posedge ref_clk);
    #1;
    out_phase = 1'b0;
    u_host.sel(1'b0);
    n_pre = rx_cnt;
    u_host.shift(8'hE0, 1, 4, 1'b0, got);
    u_host.host_line[3] = 1'b0;
    u_host.shift(8'hF0, 1, 4, 1'b0, got);
    u_host.host_line[3] = 1'b1;
    u_host.shift(8'h70, 1, 4, 1'b0, got);
    `CHK(rx_cnt - n_pre, 1)
    `CHK(rx_last, 8'hE7)
    end_of_test;
  end
endmodule // sfp_pin_front_test
